// *** design/pxb_pkg.sv ***
// Constants and types for the port and external bus pin block
package pxb_pkg;
  localparam int unsigned PORT_W        = 8;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned CLK_MHZ       = 25;
  localparam logic [1:0]  MEM_NONE      = 2'h0;
  localparam logic [1:0]  MEM_4K        = 2'h1;
  localparam logic [1:0]  MEM_16K       = 2'h2;
  localparam logic [1:0]  MEM_FULL      = 2'h3;
  localparam logic [7:0]  PF_MASK_NONE  = 8'h00;
  localparam logic [7:0]  PF_MASK_4K    = 8'h0f;
  localparam logic [7:0]  PF_MASK_16K   = 8'h3f;
  localparam logic [7:0]  PF_MASK_FULL  = 8'hff;
  localparam logic [15:0] RAM_BASE      = 16'hfc00;
  localparam logic [1:0]  ROM_4K        = 2'h0;
  localparam logic [1:0]  ROM_8K        = 2'h1;
  localparam logic [1:0]  ROM_16K       = 2'h2;
  localparam logic [1:0]  ROM_32K       = 2'h3;
  localparam logic [15:0] ROM_END_4K    = 16'h1000;
  localparam logic [15:0] ROM_END_8K    = 16'h2000;
  localparam logic [15:0] ROM_END_16K   = 16'h4000;
  localparam logic [15:0] ROM_END_32K   = 16'h8000;
  localparam logic [7:0]  PC_ALT_SCK    = 8'h04;
  localparam logic [7:0]  PC_ALT_TOUT   = 8'h10;
  localparam int unsigned TIMER_W       = 8;
  typedef enum logic [2:0] {PXB_IDLE, PXB_ALE, PXB_SETUP, PXB_STROBE, PXB_HOLD} pxb_bus_e;
endpackage : pxb_pkg

// *** design/pxb_top.sv ***
// Port lines, multiplexed external bus and edge-triggered inputs
//
// Overview of operation
// - Pulse address latch strobe so external latch captures low address byte.
// - Ports A, B, C: per-bit direction, all inputs after reset.
// - Each port C line selectable as general line or peripheral control line.
// - Port D direction set for whole byte only.
// - With external memory, port D becomes multiplexed address and data bus.
// - Port F per-bit direction; drives upper address with external memory.
// - Read strobe low only during an external read cycle.
// - Write strobe low only during an external write cycle.
// - Strobes float during reset and during hardware stop.
// - First maskable interrupt latches on rising edge.
// - Second maskable interrupt latches on falling edge.
// - Nonmaskable interrupt latches on falling edge, never masked.
// - Upper four analog pins detect falling edges as digital inputs.
// - Reset low clears configuration, bus state, port directions and edge latches; the timer keeps running.
// - Stop input low halts the system clock.
// - Serial clock pin driven when internal clock, input when external.
// - 64K space, top region on-chip RAM, rest ROM or RAM.
// - Internal program memory size selectable 4K, 8K, 16K or 32K.
// - Timer output pin gives square wave at timer-set frequency.
// - Memory size sets how many port F lines carry address.
`timescale 1ns/1ns
`default_nettype none
module pxb_top #(
  parameter int unsigned W = pxb_pkg::PORT_W
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     reset_in_n,
  input  wire logic                     stop_in_n,
  input  wire logic [1:0]               mem_size,
  input  wire logic                     mem_size_sel_lo,
  input  wire logic                     mem_size_sel_hi,
  input  wire logic                     romless,
  input  wire logic [1:0]               rom_size,
  input  wire logic                     rom_size_we,
  input  wire logic [W-1:0]             port_a_dir,
  input  wire logic [W-1:0]             port_a_wdata,
  input  wire logic [W-1:0]             port_b_dir,
  input  wire logic [W-1:0]             port_b_wdata,
  input  wire logic [W-1:0]             port_c_dir,
  input  wire logic [W-1:0]             port_c_wdata,
  input  wire logic [W-1:0]             port_c_alt,
  input  wire logic [W-1:0]             port_c_alt_out,
  input  wire logic                     port_d_out_en,
  input  wire logic [W-1:0]             port_d_wdata,
  input  wire logic [W-1:0]             port_f_dir,
  input  wire logic [W-1:0]             port_f_wdata,
  input  wire logic                     sck_internal,
  input  wire logic                     sck_gen,
  input  wire logic [pxb_pkg::TIMER_W-1:0] timer_reload,
  input  wire logic                     bus_req,
  input  wire logic                     bus_write,
  input  wire logic [pxb_pkg::ADDR_W-1:0] bus_addr,
  input  wire logic [W-1:0]             bus_wdata,
  input  wire logic [W-1:0]             port_a_lines_i,
  input  wire logic [W-1:0]             port_b_lines_i,
  input  wire logic [W-1:0]             port_c_lines_i,
  input  wire logic [W-1:0]             port_d_lines_i,
  input  wire logic [W-1:0]             port_f_lines_i,
  input  wire logic                     rise_edge_irq_in,
  input  wire logic                     fall_edge_irq_in_n,
  input  wire logic                     nmi_in_n,
  input  wire logic [3:0]               upper_analog_pins,
  input  wire logic                     irq_ack,
  output logic [W-1:0]                  port_a_lines_o,
  output logic [W-1:0]                  port_a_lines_oe,
  output logic [W-1:0]                  port_b_lines_o,
  output logic [W-1:0]                  port_b_lines_oe,
  output logic [W-1:0]                  port_c_lines_o,
  output logic [W-1:0]                  port_c_lines_oe,
  output logic [W-1:0]                  port_d_lines_o,
  output logic [W-1:0]                  port_d_lines_oe,
  output logic [W-1:0]                  port_f_lines_o,
  output logic [W-1:0]                  port_f_lines_oe,
  output logic [W-1:0]                  port_a_rdata,
  output logic [W-1:0]                  port_b_rdata,
  output logic [W-1:0]                  port_c_rdata,
  output logic [W-1:0]                  port_d_rdata,
  output logic [W-1:0]                  port_f_rdata,
  output logic                          addr_latch,
  output logic                          rd_n_o,
  output logic                          rd_n_oe,
  output logic                          wr_n_o,
  output logic                          wr_n_oe,
  output logic                          bus_done,
  output logic [W-1:0]                  bus_rdata,
  output logic                          bus_internal,
  output logic                          irq_rise,
  output logic                          irq_fall,
  output logic                          irq_nmi,
  output logic [3:0]                    analog_fall,
  output logic                          osc_halt,
  output logic                          dev_reset,
  output logic [1:0]                    ext_mem_cfg,
  output logic [1:0]                    rom_size_cfg
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers: two flops for every pin input
  localparam int unsigned NS = 5*W + 8;
  logic [NS-1:0] pin_raw, sync1, sync2;
  // Edge detectors only look back at the interrupt and analog bits
  logic [6:0]    prev;
  assign pin_raw = {port_a_lines_i, port_b_lines_i, port_c_lines_i, port_d_lines_i, port_f_lines_i,
                    rise_edge_irq_in, fall_edge_irq_in_n, nmi_in_n, upper_analog_pins, reset_in_n};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '1;
      sync2 <= '1;
      prev  <= '1;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      prev  <= sync2[7:1];
    end
  end
  logic [W-1:0] s_pa, s_pb, s_pc, s_pd, s_pf;
  logic         s_rise_edge_irq_in, s_fall_edge_irq_in_n_n, s_nmi_n, s_rst_n, p_rise_edge_irq_in, p_fall_edge_irq_in_n_n, p_nmi_n;
  logic [3:0]   s_an, p_an;
  assign {s_pa, s_pb, s_pc, s_pd, s_pf, s_rise_edge_irq_in, s_fall_edge_irq_in_n_n, s_nmi_n, s_an, s_rst_n} = sync2;
  assign {p_rise_edge_irq_in, p_fall_edge_irq_in_n_n, p_nmi_n, p_an} = prev;

  // Stop pin has its own pair, reset-initialised high; the mode pin pair resets low
  logic       stop_s1, stop_s2;
  logic [1:0] mode_s1, mode_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_s1 <= 1'b1;
      stop_s2 <= 1'b1;
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
    end else begin
      stop_s1 <= stop_in_n;
      stop_s2 <= stop_s1;
      mode_s1 <= {mem_size_sel_hi, mem_size_sel_lo};
      mode_s2 <= mode_s1;
    end
  end
  logic dev_rst;
  assign dev_rst = !s_rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture
  logic [1:0] ext_cfg;
  always_comb begin
    ext_cfg = mem_size;
    if (romless) begin
      ext_cfg = mode_s2 == 2'h0 ? pxb_pkg::MEM_4K :
                (mode_s2[1] ? pxb_pkg::MEM_FULL : pxb_pkg::MEM_16K);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_mem_cfg  <= pxb_pkg::MEM_NONE;
      rom_size_cfg <= pxb_pkg::ROM_32K;
      dev_reset    <= 1'b1;
      osc_halt     <= 1'b0;
    end else begin
      dev_reset <= dev_rst;
      osc_halt  <= !stop_s2;
      if (dev_rst) begin
        ext_mem_cfg  <= pxb_pkg::MEM_NONE;
        rom_size_cfg <= pxb_pkg::ROM_32K;
      end else begin
        ext_mem_cfg <= ext_cfg;
        if (rom_size_we) begin
          rom_size_cfg <= rom_size;
        end
      end
    end
  end

  logic       ext_on;
  logic [7:0] pf_amask;
  assign ext_on = ext_mem_cfg != pxb_pkg::MEM_NONE;
  always_comb begin
    case (ext_mem_cfg)
      pxb_pkg::MEM_4K:   pf_amask = pxb_pkg::PF_MASK_4K;
      pxb_pkg::MEM_16K:  pf_amask = pxb_pkg::PF_MASK_16K;
      pxb_pkg::MEM_FULL: pf_amask = pxb_pkg::PF_MASK_FULL;
      default:           pf_amask = pxb_pkg::PF_MASK_NONE;
    endcase
  end

  // Internal decode: on-chip RAM at top, program memory below its limit
  logic [15:0] rom_end;
  logic        addr_int;
  always_comb begin
    case (rom_size_cfg)
      pxb_pkg::ROM_4K:  rom_end = pxb_pkg::ROM_END_4K;
      pxb_pkg::ROM_8K:  rom_end = pxb_pkg::ROM_END_8K;
      pxb_pkg::ROM_16K: rom_end = pxb_pkg::ROM_END_16K;
      default:          rom_end = pxb_pkg::ROM_END_32K;
    endcase
  end
  assign addr_int = (bus_addr >= pxb_pkg::RAM_BASE) || (!romless && bus_addr < rom_end);

  ////////////////////////////////////////////////////////////////////////////
  // External bus sequencer
  pxb_pkg::pxb_bus_e st;
  logic [15:0] a_q;
  logic [7:0]  d_q;
  logic        w_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= pxb_pkg::PXB_IDLE;
      a_q <= 16'h0000;
      d_q <= 8'h00;
      w_q <= 1'b0;
      bus_done <= 1'b0;
      bus_internal <= 1'b0;
      bus_rdata <= 8'h00;
    end else begin
      bus_done <= 1'b0;
      bus_internal <= 1'b0;
      if (dev_rst || osc_halt) begin
        st <= pxb_pkg::PXB_IDLE;
      end else begin
        case (st)
          pxb_pkg::PXB_IDLE: if (bus_req) begin
            if (addr_int || !ext_on) begin
              bus_internal <= 1'b1;
              bus_done <= 1'b1;
            end else begin
              a_q <= bus_addr;
              d_q <= bus_wdata;
              w_q <= bus_write;
              st  <= pxb_pkg::PXB_ALE;
            end
          end
          pxb_pkg::PXB_ALE:    st <= pxb_pkg::PXB_SETUP;
          pxb_pkg::PXB_SETUP:  st <= pxb_pkg::PXB_STROBE;
          pxb_pkg::PXB_STROBE: st <= pxb_pkg::PXB_HOLD;
          pxb_pkg::PXB_HOLD: begin
            // Synchronised pins lag two edges, so the byte is taken one state late
            if (!w_q) begin
              bus_rdata <= s_pd;
            end
            bus_done <= 1'b1;
            st <= pxb_pkg::PXB_IDLE;
          end
          default: st <= pxb_pkg::PXB_IDLE;
        endcase
      end
    end
  end
  logic in_bus;
  assign in_bus = st != pxb_pkg::PXB_IDLE;

  // Address latch pulse, read and write strobes and their enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_latch <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      rd_n_oe <= 1'b0;
      wr_n_oe <= 1'b0;
    end else begin
      addr_latch <= st == pxb_pkg::PXB_IDLE && bus_req && !addr_int && ext_on && !dev_rst && !osc_halt;
      rd_n_o <= !((st == pxb_pkg::PXB_ALE || st == pxb_pkg::PXB_SETUP) && !w_q);
      wr_n_o <= !((st == pxb_pkg::PXB_ALE || st == pxb_pkg::PXB_SETUP) && w_q);
      rd_n_oe <= !dev_rst && stop_s2;
      wr_n_oe <= !dev_rst && stop_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer square wave on its alternate port C line
  logic [pxb_pkg::TIMER_W-1:0] tcnt;
  logic                        tsq;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tcnt <= '0;
      tsq  <= 1'b0;
    end else if (tcnt == '0) begin
      tcnt <= timer_reload;
      tsq  <= !tsq;
    end else begin
      tcnt <= tcnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port pins
  logic [W-1:0] c_alt_val, c_alt_oe;
  always_comb begin
    c_alt_val = port_c_alt_out;
    c_alt_oe  = port_c_dir;
    c_alt_val = (c_alt_val & ~pxb_pkg::PC_ALT_SCK & ~pxb_pkg::PC_ALT_TOUT)
              | (sck_gen ? pxb_pkg::PC_ALT_SCK : 8'h00) | (tsq ? pxb_pkg::PC_ALT_TOUT : 8'h00);
    c_alt_oe  = (c_alt_oe & ~pxb_pkg::PC_ALT_SCK) | (sck_internal ? pxb_pkg::PC_ALT_SCK : 8'h00);
    c_alt_oe  = c_alt_oe | pxb_pkg::PC_ALT_TOUT;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_a_lines_o <= '0; port_a_lines_oe <= '0;
      port_b_lines_o <= '0; port_b_lines_oe <= '0;
      port_c_lines_o <= '0; port_c_lines_oe <= '0;
      port_d_lines_o <= '0; port_d_lines_oe <= '0;
      port_f_lines_o <= '0; port_f_lines_oe <= '0;
    end else if (dev_rst) begin
      port_a_lines_oe <= '0;
      port_b_lines_oe <= '0;
      port_c_lines_oe <= '0;
      port_d_lines_oe <= '0;
      port_f_lines_oe <= '0;
    end else begin
      port_a_lines_o <= port_a_wdata;  port_a_lines_oe <= port_a_dir;
      port_b_lines_o <= port_b_wdata;  port_b_lines_oe <= port_b_dir;
      for (int i = 0; i < W; i++) begin
        port_c_lines_o[i]  <= port_c_alt[i] ? c_alt_val[i] : port_c_wdata[i];
        port_c_lines_oe[i] <= port_c_alt[i] ? c_alt_oe[i] : port_c_dir[i];
      end
      if (ext_on) begin
        // Address shown only during the latch pulse; data follows on writes
        port_d_lines_o  <= (st == pxb_pkg::PXB_IDLE) ? bus_addr[7:0] : (w_q ? d_q : a_q[7:0]);
        port_d_lines_oe <= {W{(st == pxb_pkg::PXB_IDLE && bus_req && !addr_int) || (in_bus && w_q)}};
      end else begin
        port_d_lines_o  <= port_d_wdata;
        port_d_lines_oe <= {W{port_d_out_en}};
      end
      for (int i = 0; i < W; i++) begin
        port_f_lines_o[i]  <= pf_amask[i] ? (in_bus ? a_q[8+i] : bus_addr[8+i]) : port_f_wdata[i];
        port_f_lines_oe[i] <= pf_amask[i] ? 1'b1 : port_f_dir[i];
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_a_rdata <= '0; port_b_rdata <= '0; port_c_rdata <= '0; port_d_rdata <= '0; port_f_rdata <= '0;
    end else begin
      port_a_rdata <= s_pa; port_b_rdata <= s_pb; port_c_rdata <= s_pc;
      port_d_rdata <= s_pd; port_f_rdata <= s_pf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge-latched requests, held until acknowledged; a new edge beats the ack
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_rise <= 1'b0; irq_fall <= 1'b0; irq_nmi <= 1'b0; analog_fall <= '0;
    end else if (dev_rst) begin
      irq_rise <= 1'b0; irq_fall <= 1'b0; irq_nmi <= 1'b0; analog_fall <= '0;
    end else begin
      irq_rise <= (s_rise_edge_irq_in && !p_rise_edge_irq_in) || (irq_rise && !irq_ack);
      irq_fall <= (!s_fall_edge_irq_in_n_n && p_fall_edge_irq_in_n_n) || (irq_fall && !irq_ack);
      irq_nmi  <= (!s_nmi_n && p_nmi_n) || (irq_nmi && !irq_ack);
      analog_fall <= (~s_an & p_an) | (analog_fall & {4{!irq_ack}});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_strobe_float: assert property (@(posedge clk) disable iff (rst)
    $fell(stop_s2) |=> !rd_n_oe && !wr_n_oe) else $error("strobes not floated in stop");
  a_rd_only_read: assert property (@(posedge clk) disable iff (rst)
    !rd_n_o |-> $past(in_bus) && !w_q) else $error("read strobe outside read cycle");
  a_wr_only_write: assert property (@(posedge clk) disable iff (rst)
    !wr_n_o |-> $past(in_bus) && w_q) else $error("write strobe outside write cycle");
  a_ale_first: assert property (@(posedge clk) disable iff (rst)
    addr_latch |-> (rd_n_o && wr_n_o) ##1 (!rd_n_o || !wr_n_o)[*2]) else $error("strobe order wrong");
  a_nmi_edge: assert property (@(posedge clk) disable iff (rst || dev_rst)
    (!s_nmi_n && p_nmi_n) |=> irq_nmi) else $error("nmi edge lost");
  a_rise_edge: assert property (@(posedge clk) disable iff (rst || dev_rst)
    (s_rise_edge_irq_in && !p_rise_edge_irq_in) |=> irq_rise) else $error("rising edge lost");
  a_fall_edge: assert property (@(posedge clk) disable iff (rst || dev_rst)
    (!s_fall_edge_irq_in_n_n && p_fall_edge_irq_in_n_n) |=> irq_fall) else $error("falling edge lost");
  a_reset_inputs: assert property (@(posedge clk) disable iff (rst)
    dev_rst |=> port_a_lines_oe == '0 && port_b_lines_oe == '0 && port_c_lines_oe == '0)
    else $error("ports not inputs in reset");
  a_pf_addr: assert property (@(posedge clk) disable iff (rst || dev_rst)
    ext_mem_cfg == pxb_pkg::MEM_4K && $stable(ext_mem_cfg) |=> port_f_lines_oe[3:0] == 4'hf)
    else $error("port f address lines not driven");
  c_read_cycle:  cover property (@(posedge clk) addr_latch && !bus_write ##2 !rd_n_o);
  c_write_cycle: cover property (@(posedge clk) addr_latch && bus_write ##2 !wr_n_o);
  c_nmi:         cover property (@(posedge clk) $rose(irq_nmi));
  c_stop:        cover property (@(posedge clk) $rose(osc_halt));
endmodule : pxb_top
`default_nettype wire

// *** verification/pxb_ext_mem.sv ***
// External memory and address latch model on the multiplexed bus
`timescale 1ns/1ns
`default_nettype none
module pxb_ext_mem (
  input  wire logic       clk,
  input  wire logic       addr_latch,
  input  wire logic [7:0] ad_in,
  input  wire logic [7:0] hi_addr,
  input  wire logic [7:0] hi_oe,
  input  wire logic       rd_n,
  input  wire logic       rd_oe,
  input  wire logic       wr_n,
  input  wire logic       wr_oe,
  output logic [7:0]      ad_out,
  output int              order_errs
);
  logic [7:0]  mem [0:65535];
  logic [15:0] lat = 16'h0000;
  logic [7:0]  last = 8'h00;
  logic        armed = 1'b0;
  logic        was_act = 1'b0;
  wire logic   rd_act = rd_oe && (rd_n === 1'b0);
  wire logic   wr_act = wr_oe && (wr_n === 1'b0);
  initial order_errs = 0;
  ////////////////////////////////////////////////////////////
  // Released bus shows the inverse of the last byte read, so a sample taken after the strobe cannot pass
  assign ad_out = rd_act ? mem[lat] : ~last;
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    was_act <= rd_act || wr_act;
    if (addr_latch) begin
      lat   <= {hi_addr & hi_oe, ad_in};
      armed <= 1'b1;
    end
    // Strobe without a fresh latch, or address moving under the strobe
    if ((rd_act || wr_act) && (!armed || addr_latch || (hi_addr & hi_oe) !== lat[15:8])) begin
      order_errs <= order_errs + 1;
    end
    if (wr_act) begin
      mem[lat] <= ad_in;
    end
    if (rd_act) begin
      last <= mem[lat];
    end
    if (was_act && !(rd_act || wr_act)) begin
      armed <= 1'b0;
    end
  end
endmodule // pxb_ext_mem
`default_nettype wire

// *** verification/pxb_top_bench.sv ***
// Self-checking bench for the port and external bus pin block
`timescale 1ns/1ns
`default_nettype none
module pxb_top_bench;
  typedef struct packed {
    logic rl; logic hi; logic lo; logic [1:0] ms; logic [15:0] a; logic [7:0] d; logic [7:0] m; logic [1:0] cfg;
    logic in;
  } pxb_row_s;
  logic clk = 0, rst = 1, reset_in_n = 1, stop_in_n = 1, mem_size_sel_lo = 0, mem_size_sel_hi = 0, romless = 1;
  logic rom_size_we = 0, port_d_out_en = 0, sck_internal = 0, sck_gen = 0, bus_req = 0, bus_write = 0;
  logic rise_edge_irq_in = 0, fall_edge_irq_in_n = 1, nmi_in_n = 1, irq_ack = 0;
  logic [1:0] mem_size = 2'h0, rom_size = 2'h0;
  logic [7:0] port_a_dir = 8'h00, port_a_wdata = 8'h00, port_b_dir = 8'h00, port_b_wdata = 8'h00;
  logic [7:0] port_c_dir = 8'h00, port_c_wdata = 8'h00, port_c_alt = 8'h00, port_c_alt_out = 8'h00;
  logic [7:0] port_d_wdata = 8'h00, port_f_dir = 8'h00, port_f_wdata = 8'h00, timer_reload = 8'h00;
  logic [7:0] bus_wdata = 8'h00, port_a_lines_i = 8'h00, port_b_lines_i = 8'h00, port_c_lines_i = 8'h00;
  logic [7:0] port_f_lines_i = 8'h00;
  logic [15:0] bus_addr = 16'h0000;
  logic [3:0] upper_analog_pins = 4'hf;
  logic [7:0] port_a_lines_o, port_a_lines_oe, port_b_lines_o, port_b_lines_oe, port_c_lines_o, port_c_lines_oe;
  logic [7:0] port_d_lines_o, port_d_lines_oe, port_f_lines_o, port_f_lines_oe, bus_rdata, ext_ad;
  logic [7:0] port_a_rdata, port_b_rdata, port_c_rdata, port_d_rdata, port_f_rdata, v, fm;
  logic addr_latch, rd_n_o, rd_n_oe, wr_n_o, wr_n_oe, bus_done, bus_internal, irq_rise, irq_fall, irq_nmi;
  logic osc_halt, dev_reset, si, bs, ss, t;
  logic [3:0] analog_fall;
  logic [1:0] ext_mem_cfg, rom_size_cfg;
  wire logic [7:0] port_d_lines_i = (port_d_lines_oe & port_d_lines_o) | (~port_d_lines_oe & ext_ad);
  int mismatches = 0, total_checks = 0, order_errs, n;
  pxb_row_s rows [6];
  pxb_top uut (.clk, .rst, .reset_in_n, .stop_in_n, .mem_size, .mem_size_sel_lo, .mem_size_sel_hi, .romless,
    .rom_size, .rom_size_we, .port_a_dir, .port_a_wdata, .port_b_dir, .port_b_wdata, .port_c_dir, .port_c_wdata,
    .port_c_alt, .port_c_alt_out, .port_d_out_en, .port_d_wdata, .port_f_dir, .port_f_wdata, .sck_internal,
    .sck_gen, .timer_reload, .bus_req, .bus_write, .bus_addr, .bus_wdata, .port_a_lines_i, .port_b_lines_i,
    .port_c_lines_i, .port_d_lines_i, .port_f_lines_i, .rise_edge_irq_in, .fall_edge_irq_in_n, .nmi_in_n,
    .upper_analog_pins, .irq_ack, .port_a_lines_o, .port_a_lines_oe, .port_b_lines_o, .port_b_lines_oe,
    .port_c_lines_o, .port_c_lines_oe, .port_d_lines_o, .port_d_lines_oe, .port_f_lines_o, .port_f_lines_oe,
    .port_a_rdata, .port_b_rdata, .port_c_rdata, .port_d_rdata, .port_f_rdata, .addr_latch, .rd_n_o, .rd_n_oe,
    .wr_n_o, .wr_n_oe, .bus_done, .bus_rdata, .bus_internal, .irq_rise, .irq_fall, .irq_nmi, .analog_fall,
    .osc_halt, .dev_reset, .ext_mem_cfg, .rom_size_cfg);
  pxb_ext_mem ext (.clk(clk), .addr_latch(addr_latch), .ad_in(port_d_lines_o), .hi_addr(port_f_lines_o),
    .hi_oe(port_f_lines_oe), .rd_n(rd_n_o), .rd_oe(rd_n_oe), .wr_n(wr_n_o), .wr_oe(wr_n_oe), .ad_out(ext_ad),
    .order_errs(order_errs));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Holds the request until done; flags a wrong strobe and notes the F lines used as address
  task automatic bus_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int k;
    @(negedge clk);
    bus_req = 1;
    bus_write = wr;
    bus_addr = a;
    bus_wdata = d;
    fm = 8'h00;
    si = 0;
    bs = 0;
    ss = 0;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      #1;
      fm = fm | port_f_lines_oe;
      si = si | (bus_internal === 1'b1);
      bs = bs | ((wr ? rd_n_o : wr_n_o) === 1'b0 && (wr ? rd_n_oe : wr_n_oe) === 1'b1);
      ss = ss | ((wr ? wr_n_o : rd_n_o) === 1'b0 && (wr ? wr_n_oe : rd_n_oe) === 1'b1);
      if (bus_done === 1'b1) break;
    end
    v = bus_rdata;
    if (k == 20) check(1'b0, 1'b1);
    @(negedge clk);
    bus_req = 0;
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial begin
    rows[0] = {1'b1, 1'b0, 1'b0, 2'h0, 16'h0ab5, 8'h3c, 8'h0f, pxb_pkg::MEM_4K, 1'b0};
    rows[1] = {1'b1, 1'b0, 1'b1, 2'h0, 16'h2f0e, 8'hc3, 8'h3f, pxb_pkg::MEM_16K, 1'b0};
    rows[2] = {1'b1, 1'b1, 1'b0, 2'h0, 16'he7f1, 8'h5a, 8'hff, pxb_pkg::MEM_FULL, 1'b0};
    rows[3] = {1'b1, 1'b1, 1'b1, 2'h0, 16'hfbff, 8'h96, 8'hff, pxb_pkg::MEM_FULL, 1'b0};
    rows[4] = {1'b0, 1'b0, 1'b0, pxb_pkg::MEM_FULL, 16'h9001, 8'h69, 8'hff, pxb_pkg::MEM_FULL, 1'b0};
    rows[5] = {1'b1, 1'b0, 1'b0, 2'h0, pxb_pkg::RAM_BASE, 8'h11, 8'h0f, pxb_pkg::MEM_4K, 1'b1};
    wait_cyc(2);
    check({dev_reset, rd_n_oe, wr_n_oe, irq_rise, irq_nmi}, 5'h10);
    check({port_a_lines_oe, port_c_lines_oe}, 16'h0000);
    wait_cyc(2);
    rst = 0;
    wait_cyc(4);
    check(rom_size_cfg, pxb_pkg::ROM_32K);
    check({rd_n_o, rd_n_oe, wr_n_o, wr_n_oe}, 4'hf);
    $display("test reset done");
    foreach (rows[i]) begin
      romless = rows[i].rl;
      mem_size_sel_hi = rows[i].hi;
      mem_size_sel_lo = rows[i].lo;
      mem_size = rows[i].ms;
      wait_cyc(3);
      check(ext_mem_cfg, rows[i].cfg);
      bus_op(1'b1, rows[i].a, rows[i].d);
      check(fm, rows[i].m);
      check(si, rows[i].in);
      check({bs, ss}, {1'b0, !rows[i].in});
      bus_op(1'b0, rows[i].a, 8'h00);
      if (!rows[i].in) check(v, rows[i].d);
      check({bs, ss}, {1'b0, !rows[i].in});
    end
    check(order_errs, 0);
    $display("test bus rows done");
    romless = 0;
    mem_size = pxb_pkg::MEM_NONE;
    port_a_dir = 8'ha5;
    port_a_wdata = 8'h3c;
    port_a_lines_i = 8'h96;
    port_d_out_en = 1;
    port_d_wdata = 8'h5e;
    port_f_dir = 8'h81;
    port_f_wdata = 8'h24;
    port_b_dir = 8'h0f;
    port_b_wdata = 8'h5a;
    port_c_lines_i = 8'h3c;
    port_c_alt = pxb_pkg::PC_ALT_SCK;
    sck_internal = 1;
    wait_cyc(4);
    check({port_a_lines_oe, port_a_lines_o & 8'ha5}, 16'ha524);
    check(port_a_rdata, 8'h96);
    check({port_d_lines_oe, port_d_lines_o}, 16'hff5e);
    check(port_f_lines_oe, 8'h81);
    check(port_f_lines_o, 8'h24);
    check({port_b_lines_oe, port_b_lines_o}, 16'h0f5a);
    check(port_c_rdata, 8'h3c);
    check(port_c_lines_oe[2], 1'b1);
    sck_internal = 0;
    wait_cyc(4);
    check(port_c_lines_oe[2], 1'b0);
    port_c_alt = pxb_pkg::PC_ALT_TOUT;
    timer_reload = 8'h03;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      #1;
      t = port_c_lines_o[4];
      // Second pass starts one edge after the last toggle
      n = 1;
      while (port_c_lines_o[4] === t && n < 40) begin
        @(posedge clk);
        #1;
        n++;
      end
    end
    check(n, 4);
    $display("test ports done");
    @(negedge clk);
    rise_edge_irq_in = 1;
    fall_edge_irq_in_n = 0;
    nmi_in_n = 0;
    upper_analog_pins = 4'h5;
    wait_cyc(6);
    check({irq_rise, irq_fall, irq_nmi, analog_fall}, 7'h7a);
    irq_ack = 1;
    @(negedge clk);
    irq_ack = 0;
    rise_edge_irq_in = 0;
    fall_edge_irq_in_n = 1;
    nmi_in_n = 1;
    upper_analog_pins = 4'hf;
    wait_cyc(6);
    check({irq_rise, irq_fall, irq_nmi, analog_fall}, 7'h00);
    $display("test edges done");
    reset_in_n = 0;
    wait_cyc(5);
    check({dev_reset, rd_n_oe, wr_n_oe, port_a_lines_oe}, 11'h400);
    reset_in_n = 1;
    wait_cyc(5);
    check(dev_reset, 1'b0);
    stop_in_n = 0;
    wait_cyc(5);
    check({osc_halt, rd_n_oe, wr_n_oe}, 3'h4);
    stop_in_n = 1;
    wait_cyc(5);
    for (int r = 0; r < 4; r++) begin
      rom_size = r[1:0];
      rom_size_we = 1;
      @(negedge clk);
      rom_size_we = 0;
      wait_cyc(2);
      check(rom_size_cfg, r[1:0]);
    end
    $display("test reset pin, stop and rom size done");
    print_verdict();
  end
endmodule // pxb_top_bench
`default_nettype wire
